/* File: rtl/ealac_top.sv */
// access-permission checker for the 512-byte nonvolatile store
// assumes command decode, crypto engines and the store sit outside;
// all inputs come from logic on clock_i
//
// What this block does
// R01 - fully locked: plain access only, no cipher/hash
// R02 - state 10: hash read, writes; no plain read
// R03 - state 00: plain access only, no cipher/hash
// R04 - transport key never writable
// R05 - state 10 ciphered write decrypts with transport key
// R06 - locking clears factory tag, byte becomes 0xff
// R07 - factory serial never writable
// R08 - serial by fetch; second block hashable
// R09 - plain read never touches first 48 bytes
// R10 - config bit 0 returns password clear
// R11 - connect bit demands matching session secret
// R12 - locked: password slots fully closed
// R13 - four counters, locked means increment only
// R14 - block refuses bumps at 6.4 million
// R15 - counter commands need no authentication
// R16 - unlocked counters open to memory commands
// R17 - seed accessible only while unlocked
// R18 - locked read-only region: reads once startup done, no writes
// R19 - read-only region 0x110 to bound minus one
// R20 - host keeps boundary within legal range
// R21 - lock command makes lock byte 0xff forever
// R22 - no move between the two unlocked states
// R23 - forbidden command: no change, error reported

module ealac_top #(
	parameter int CTR_NUM = 4
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic lock_load_valid_i,
	input wire logic [7:0] lock_load_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [3:0] req_cmd_i,
	input wire logic [8:0] req_addr_i,
	input wire logic [7:0] cfg_byte_i,
	input wire logic [22:0] ctr_value_i,
	input wire logic auth_valid_i,
	input wire logic [3:0] auth_secret_i,
	input wire logic startup_done_i,
	input wire logic [7:0] rw_bound_i,
	output logic resp_valid_o,
	output logic resp_grant_o,
	output logic [2:0] resp_err_o,
	output logic resp_decrypt_o,
	output logic resp_clear_o,
	output logic [7:0] lock_byte_o,
	output logic nv_lock_we_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	ealac_pkg::ealac_state_t state_r, state_nxt;
	logic [7:0] lock_r;
	logic loaded_r;
	logic [3:0] cmd_r;
	logic [8:0] addr_r;
	logic [7:0] cfg_r;
	logic [22:0] ctr_r;
	logic auth_r;
	logic [3:0] secret_r;
	logic startup_r;
	logic resp_grant_r, resp_decrypt_r, resp_clear_r, nv_we_r;
	logic [2:0] resp_err_r;
	logic dec_grant, dec_decrypt, dec_clear;
	logic [2:0] dec_err;
	logic in_tkey, in_serial, in_lock, in_header, in_first;
	logic in_pw, in_ctr, in_seed, in_ro;
	logic locked, conf, open_st, take;

	assign locked = (lock_r[1:0] == ealac_pkg::LOCK_LOCKED);
	assign conf = (lock_r[1:0] == ealac_pkg::LOCK_CONF);
	assign open_st = (lock_r[1:0] == ealac_pkg::LOCK_OPEN);
	// nothing is served until the lock byte has been fetched
	assign req_ready_o = (state_r == ealac_pkg::ST_IDLE) && loaded_r;
	assign take = req_valid_i && req_ready_o;

	ealac_region u_region (
		.addr_i(addr_r),
		.rw_bound_i(rw_bound_i),
		.tkey_o(in_tkey),
		.serial_o(in_serial),
		.lock_o(in_lock),
		.header_o(in_header),
		.first_blk_o(in_first),
		.pw_o(in_pw),
		.ctr_o(in_ctr),
		.seed_o(in_seed),
		.ro_o(in_ro)
	);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ealac_pkg::ST_IDLE: if (take) state_nxt = ealac_pkg::ST_EVAL;
			ealac_pkg::ST_EVAL: state_nxt = ealac_pkg::ST_RESP;
			ealac_pkg::ST_RESP: state_nxt = ealac_pkg::ST_IDLE;
			default: state_nxt = ealac_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) state_r <= ealac_pkg::ST_IDLE;
		else state_r <= state_nxt;
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			cmd_r <= ealac_pkg::CMD_PLAIN_READ;
			addr_r <= '0;
			cfg_r <= '0;
			ctr_r <= '0;
			auth_r <= 1'b0;
			secret_r <= '0;
			startup_r <= 1'b0;
		end else if (take) begin
			cmd_r <= req_cmd_i;
			addr_r <= req_addr_i;
			cfg_r <= cfg_byte_i;
			ctr_r <= ctr_value_i;
			auth_r <= auth_valid_i;
			secret_r <= auth_secret_i;
			startup_r <= startup_done_i;
		end
	end

	// ----------------------------------------
	// lock byte
	// ----------------------------------------
	// one load per reset, then only the lock command may change it
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			lock_r <= ealac_pkg::LOCK_FULL;
			loaded_r <= 1'b0;
		end else if (!loaded_r && lock_load_valid_i) begin
			lock_r <= lock_load_i; // R22
			loaded_r <= 1'b1;
		end else if (state_r == ealac_pkg::ST_EVAL && cmd_r == ealac_pkg::CMD_LOCK && dec_grant) begin
			lock_r <= ealac_pkg::LOCK_FULL; // R06 R21
		end
	end

	// ----------------------------------------
	// permission decision
	// ----------------------------------------
	always_comb begin
		dec_grant = 1'b0;
		dec_err = ealac_pkg::ERR_BAD_CMD;
		dec_decrypt = 1'b0;
		dec_clear = 1'b0;
		case (cmd_r)
			ealac_pkg::CMD_PLAIN_READ: begin
				if (!(locked || open_st)) dec_grant = 1'b0; // R02
				else if (in_header) dec_grant = 1'b0; // R09 R08
				else if (locked && (in_pw || in_ctr || in_seed)) dec_grant = 1'b0; // R12 R13 R17
				else if (locked && in_ro && !startup_r) dec_err = ealac_pkg::ERR_AUTH; // R18
				else dec_grant = 1'b1; // R01 R03 R16
			end
			ealac_pkg::CMD_PLAIN_WRITE, ealac_pkg::CMD_CIPHER_WRITE: begin
				if (cmd_r == ealac_pkg::CMD_CIPHER_WRITE && !conf) dec_grant = 1'b0; // R01 R03
				else if (!(locked || conf || open_st)) dec_grant = 1'b0;
				else if (in_tkey) dec_grant = 1'b0; // R04
				else if (in_serial || in_lock) dec_grant = 1'b0; // R07 R21
				else if (locked && (in_pw || in_ctr || in_seed || in_ro)) dec_grant = 1'b0; // R12 R13 R17 R18
				else begin
					dec_grant = 1'b1; // R16
					dec_decrypt = (cmd_r == ealac_pkg::CMD_CIPHER_WRITE); // R05
				end
			end
			ealac_pkg::CMD_HASHED_READ: begin
				// any address outside the first block of the header may feed the digest
				if (conf && !in_first) dec_grant = 1'b1; // R02 R08
			end
			ealac_pkg::CMD_SERIAL_FETCH: dec_grant = 1'b1; // R08
			ealac_pkg::CMD_PW_FETCH: begin
				if (cfg_r[ealac_pkg::CFG_CONNECT_BIT] &&
						!(auth_r && secret_r == cfg_r[ealac_pkg::CFG_SECRET_MSB:ealac_pkg::CFG_SECRET_LSB])) begin
					dec_err = ealac_pkg::ERR_AUTH; // R11
				end else begin
					dec_grant = 1'b1;
					dec_clear = cfg_r[ealac_pkg::CFG_CLEAR_BIT]; // R10
				end
			end
			ealac_pkg::CMD_CTR_FETCH: begin
				if (addr_r < 9'(CTR_NUM)) dec_grant = 1'b1; // R15
			end
			ealac_pkg::CMD_CTR_BUMP: begin
				// saturate rather than wrap past the counter ceiling
				if (addr_r < 9'(CTR_NUM) && ctr_r < ealac_pkg::CTR_MAX) dec_grant = 1'b1; // R13 R14 R15
			end
			ealac_pkg::CMD_LOCK: begin
				if (!locked) dec_grant = 1'b1; // R21
			end
			default: dec_grant = 1'b0;
		endcase
		if (dec_grant) dec_err = ealac_pkg::ERR_OK;
	end

	// ----------------------------------------
	// answer
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			resp_grant_r <= 1'b0;
			resp_err_r <= ealac_pkg::ERR_OK;
			resp_decrypt_r <= 1'b0;
			resp_clear_r <= 1'b0;
		end else if (state_r == ealac_pkg::ST_EVAL) begin
			resp_grant_r <= dec_grant; // R23
			resp_err_r <= dec_err; // R23
			resp_decrypt_r <= dec_decrypt;
			resp_clear_r <= dec_clear;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) nv_we_r <= 1'b0;
		else nv_we_r <= (state_r == ealac_pkg::ST_EVAL) && (cmd_r == ealac_pkg::CMD_LOCK) && dec_grant; // R21
	end

	assign resp_valid_o = (state_r == ealac_pkg::ST_RESP);
	assign resp_grant_o = resp_grant_r;
	assign resp_err_o = resp_err_r;
	assign resp_decrypt_o = resp_decrypt_r;
	assign resp_clear_o = resp_clear_r;
	assign lock_byte_o = lock_r;
	assign nv_lock_we_o = nv_we_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic eval;
	assign eval = (state_r == ealac_pkg::ST_EVAL);

	sequence s_take;
		req_valid_i && req_ready_o;
	endsequence

	sequence s_answer;
		##2 resp_valid_o;
	endsequence

	property p_latency;
		@(posedge clock_i) disable iff (!reset_n_i) s_take |-> s_answer;
	endproperty
	a_latency: assert property (p_latency) else $error("answer not two cycles after request"); // R23

	property p_locked_no_cipher;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && locked && (cmd_r == ealac_pkg::CMD_CIPHER_WRITE || cmd_r == ealac_pkg::CMD_HASHED_READ)
			|=> resp_valid_o && !resp_grant_o;
	endproperty
	a_locked_no_cipher: assert property (p_locked_no_cipher) else $error("cipher or hash allowed when locked"); // R01

	property p_conf_no_read;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && conf && cmd_r == ealac_pkg::CMD_PLAIN_READ |=> !resp_grant_o && resp_err_o != ealac_pkg::ERR_OK;
	endproperty
	a_conf_no_read: assert property (p_conf_no_read) else $error("plain read allowed in state 10"); // R02

	property p_open_no_hash;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && open_st && cmd_r == ealac_pkg::CMD_HASHED_READ |=> !resp_grant_o;
	endproperty
	a_open_no_hash: assert property (p_open_no_hash) else $error("hashed read allowed in state 00"); // R03

	property p_key_serial_write;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && (in_tkey || in_serial) && (cmd_r == ealac_pkg::CMD_PLAIN_WRITE || cmd_r == ealac_pkg::CMD_CIPHER_WRITE)
			|=> !resp_grant_o;
	endproperty
	a_key_serial_write: assert property (p_key_serial_write) else $error("key or serial write allowed"); // R04 R07

	property p_decrypt;
		@(posedge clock_i) disable iff (!reset_n_i)
			resp_valid_o && resp_grant_o |-> resp_decrypt_o == ($past(cmd_r) == ealac_pkg::CMD_CIPHER_WRITE);
	endproperty
	a_decrypt: assert property (p_decrypt) else $error("decrypt flag wrong"); // R05

	property p_lock_sets;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && !locked && cmd_r == ealac_pkg::CMD_LOCK |=> lock_r == ealac_pkg::LOCK_FULL && nv_lock_we_o ##1 !nv_lock_we_o;
	endproperty
	a_lock_sets: assert property (p_lock_sets) else $error("lock command did not set 0xff"); // R06

	property p_lock_stays;
		@(posedge clock_i) disable iff (!reset_n_i)
			loaded_r && lock_r == ealac_pkg::LOCK_FULL |=> lock_r == ealac_pkg::LOCK_FULL;
	endproperty
	a_lock_stays: assert property (p_lock_stays) else $error("lock byte changed after locking"); // R21

	property p_unlocked_fixed;
		@(posedge clock_i) disable iff (!reset_n_i)
			loaded_r && !locked |=> lock_r == $past(lock_r) || lock_r == ealac_pkg::LOCK_FULL;
	endproperty
	a_unlocked_fixed: assert property (p_unlocked_fixed) else $error("moved between unlocked states"); // R22

	property p_header_read;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && in_header && cmd_r == ealac_pkg::CMD_PLAIN_READ |=> !resp_grant_o;
	endproperty
	a_header_read: assert property (p_header_read) else $error("plain read of header allowed"); // R09

	property p_pw_secret;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && cmd_r == ealac_pkg::CMD_PW_FETCH && cfg_r[ealac_pkg::CFG_CONNECT_BIT] && !auth_r
			|=> !resp_grant_o && resp_err_o == ealac_pkg::ERR_AUTH;
	endproperty
	a_pw_secret: assert property (p_pw_secret) else $error("password returned without session"); // R11

	property p_locked_closed;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && locked && (in_pw || in_seed || in_ro) && cmd_r == ealac_pkg::CMD_PLAIN_WRITE |=> !resp_grant_o;
	endproperty
	a_locked_closed: assert property (p_locked_closed) else $error("locked area write allowed"); // R12 R17 R18

	property p_ctr_fetch;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && cmd_r == ealac_pkg::CMD_CTR_FETCH && addr_r < 9'(CTR_NUM) |=> resp_grant_o;
	endproperty
	a_ctr_fetch: assert property (p_ctr_fetch) else $error("counter fetch refused"); // R15

	property p_refuse_err;
		@(posedge clock_i) disable iff (!reset_n_i)
			resp_valid_o |-> resp_grant_o == (resp_err_o == ealac_pkg::ERR_OK);
	endproperty
	a_refuse_err: assert property (p_refuse_err) else $error("refusal without error code"); // R23

	property p_bump_ceiling;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && cmd_r == ealac_pkg::CMD_CTR_BUMP && ctr_r >= ealac_pkg::CTR_MAX |=> !resp_grant_o;
	endproperty
	a_bump_ceiling: assert property (p_bump_ceiling) else $error("counter bumped past ceiling"); // R14

	property p_clear_pw;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && cmd_r == ealac_pkg::CMD_PW_FETCH && !cfg_r[ealac_pkg::CFG_CONNECT_BIT]
			|=> resp_grant_o && resp_clear_o == cfg_r[ealac_pkg::CFG_CLEAR_BIT];
	endproperty
	a_clear_pw: assert property (p_clear_pw) else $error("clear password flag wrong"); // R10

	property p_ro_startup;
		@(posedge clock_i) disable iff (!reset_n_i)
			eval && locked && in_ro && !startup_r && cmd_r == ealac_pkg::CMD_PLAIN_READ
			|=> !resp_grant_o && resp_err_o == ealac_pkg::ERR_AUTH;
	endproperty
	a_ro_startup: assert property (p_ro_startup) else $error("read-only region read before startup"); // R18

endmodule // ealac_top

/* File: rtl/ealac_pkg.sv */
// shared constants for the nonvolatile store access-permission block
// assumes a 9-bit byte address into the 512-byte store

package ealac_pkg;

	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam int ADDR_W = 9;
	localparam logic [8:0] TKEY_LO = 9'h010;
	localparam logic [8:0] TKEY_HI = 9'h01f;
	localparam logic [8:0] BLK2_LO = 9'h020;
	localparam logic [8:0] SERIAL_HI = 9'h02e;
	localparam logic [8:0] LOCK_ADDR = 9'h02f;
	localparam logic [8:0] HDR_END = 9'h030;
	localparam logic [8:0] PW_HI = 9'h06f;
	localparam logic [8:0] CTR_LO = 9'h070;
	localparam logic [8:0] CTR_HI = 9'h0af;
	localparam logic [8:0] SEED_LO = 9'h0d0;
	localparam logic [8:0] SEED_HI = 9'h0df;
	localparam logic [8:0] RO_LO = 9'h110;
	localparam logic [8:0] RO_BASE = 9'h100;

	// ----------------------------------------
	// lock byte and password configuration
	// ----------------------------------------
	localparam logic [7:0] LOCK_FULL = 8'hff;
	localparam logic [1:0] LOCK_LOCKED = 2'h3;
	localparam logic [1:0] LOCK_CONF = 2'h2;
	localparam logic [1:0] LOCK_OPEN = 2'h0;
	localparam int CFG_CLEAR_BIT = 0;
	localparam int CFG_CONNECT_BIT = 1;
	localparam int CFG_SECRET_LSB = 4;
	localparam int CFG_SECRET_MSB = 7;

	// ----------------------------------------
	// counters
	// ----------------------------------------
	localparam int CTR_W = 23;
	localparam logic [22:0] CTR_MAX = 23'd6400000;

	// ----------------------------------------
	// commands and answers
	// ----------------------------------------
	localparam logic [3:0] CMD_PLAIN_READ = 4'h0;
	localparam logic [3:0] CMD_PLAIN_WRITE = 4'h1;
	localparam logic [3:0] CMD_CIPHER_WRITE = 4'h2;
	localparam logic [3:0] CMD_HASHED_READ = 4'h3;
	localparam logic [3:0] CMD_SERIAL_FETCH = 4'h4;
	localparam logic [3:0] CMD_PW_FETCH = 4'h5;
	localparam logic [3:0] CMD_CTR_FETCH = 4'h6;
	localparam logic [3:0] CMD_CTR_BUMP = 4'h7;
	localparam logic [3:0] CMD_LOCK = 4'h8;

	localparam logic [2:0] ERR_OK = 3'h0;
	localparam logic [2:0] ERR_BAD_CMD = 3'h2;
	localparam logic [2:0] ERR_AUTH = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EVAL = 3'b010,
		ST_RESP = 3'b100
	} ealac_state_t;

endpackage

/* File: rtl/ealac_region.sv */
// address region decoder for the nonvolatile store
// assumes the boundary value is kept legal by the host

module ealac_region (
	input wire logic [8:0] addr_i,
	input wire logic [7:0] rw_bound_i,
	output logic tkey_o,
	output logic serial_o,
	output logic lock_o,
	output logic header_o,
	output logic first_blk_o,
	output logic pw_o,
	output logic ctr_o,
	output logic seed_o,
	output logic ro_o
);

	logic [8:0] ro_end;

	// ----------------------------------------
	// region compares
	// ----------------------------------------
	// boundary of 0x10 or less would make the region empty; host keeps it legal
	assign ro_end = ealac_pkg::RO_BASE | {1'b0, rw_bound_i}; // R19 R20

	always_comb begin
		tkey_o = (addr_i >= ealac_pkg::TKEY_LO) && (addr_i <= ealac_pkg::TKEY_HI);
		serial_o = (addr_i >= ealac_pkg::BLK2_LO) && (addr_i <= ealac_pkg::SERIAL_HI);
		lock_o = (addr_i == ealac_pkg::LOCK_ADDR);
		header_o = (addr_i < ealac_pkg::HDR_END);
		first_blk_o = (addr_i < ealac_pkg::BLK2_LO);
		pw_o = (addr_i >= ealac_pkg::HDR_END) && (addr_i <= ealac_pkg::PW_HI);
		ctr_o = (addr_i >= ealac_pkg::CTR_LO) && (addr_i <= ealac_pkg::CTR_HI);
		seed_o = (addr_i >= ealac_pkg::SEED_LO) && (addr_i <= ealac_pkg::SEED_HI);
		ro_o = (addr_i >= ealac_pkg::RO_LO) && (addr_i < ro_end); // R19
	end

endmodule // ealac_region

/* File: tb/ealac_host.sv */
// host-side model: offers one command at a time to the permission block
// assumes it shares clock_i with the block and that the bench calls issue
module ealac_host (
	input wire logic clock_i,
	input wire logic req_ready_i,
	input wire logic resp_valid_i,
	input wire logic resp_grant_i,
	input wire logic [2:0] resp_err_i,
	input wire logic resp_decrypt_i,
	input wire logic resp_clear_i,
	input wire logic nv_lock_we_i,
	output logic req_valid_o,
	output logic [3:0] req_cmd_o,
	output logic [8:0] req_addr_o,
	output logic [7:0] cfg_byte_o,
	output logic [22:0] ctr_value_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		req_valid_o = 1'b0;
		req_cmd_o = 4'hf;
		req_addr_o = 9'h1ff;
		cfg_byte_o = 8'hff;
		ctr_value_o = 23'h7fffff;
	end

	// --------------------------------
	// one request, answer taken in c2
	// --------------------------------
	task automatic issue(input logic [3:0] cmd, input logic [8:0] addr, input logic [7:0] cfg,
		input logic [22:0] ctr, output logic [6:0] ans, output logic seen);
		int n;
		n = 0;
		@(posedge clock_i);
		#1;
		req_valid_o = 1'b1;
		req_cmd_o = cmd;
		req_addr_o = addr;
		cfg_byte_o = cfg;
		ctr_value_o = ctr;
		// ready is combinational, so judge it mid-cycle before the taking edge
		do begin
			@(negedge clock_i);
			n++;
		end while (req_ready_i !== 1'b1 && n < 50);
		@(posedge clock_i);
		#1;
		// released lines must not keep showing the old request
		req_valid_o = 1'b0;
		req_cmd_o = ~cmd;
		req_addr_o = ~addr;
		cfg_byte_o = ~cfg;
		ctr_value_o = ~ctr;
		@(negedge clock_i);
		@(negedge clock_i);
		seen = (resp_valid_i === 1'b1);
		ans = {resp_grant_i, resp_err_i, resp_decrypt_i, resp_clear_i, nv_lock_we_i};
	endtask
endmodule // ealac_host

/* File: tb/test_eeprom_lock_access_control.sv */
// self-checking bench for the store access-permission block
// assumes the host model in ealac_host and the design package
module test_eeprom_lock_access_control;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [3:0] PR = ealac_pkg::CMD_PLAIN_READ;
	localparam logic [3:0] PW = ealac_pkg::CMD_PLAIN_WRITE;
	localparam logic [3:0] CW = ealac_pkg::CMD_CIPHER_WRITE;
	localparam logic [3:0] HR = ealac_pkg::CMD_HASHED_READ;
	localparam logic [3:0] SF = ealac_pkg::CMD_SERIAL_FETCH;
	localparam logic [3:0] PF = ealac_pkg::CMD_PW_FETCH;
	localparam logic [3:0] CF = ealac_pkg::CMD_CTR_FETCH;
	localparam logic [3:0] CB = ealac_pkg::CMD_CTR_BUMP;
	localparam logic [3:0] LK = ealac_pkg::CMD_LOCK;
	// expected answer {grant, err, decrypt, clear}
	localparam logic [5:0] G = 6'h20;
	localparam logic [5:0] GD = 6'h22;
	localparam logic [5:0] GC = 6'h21;
	localparam logic [5:0] R2 = 6'h08;
	localparam logic [5:0] R4 = 6'h10;

	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic lock_load_valid_i = 1'b0;
	logic [7:0] lock_load_i = 8'h00;
	logic auth_valid_i = 1'b0;
	logic [3:0] auth_secret_i = 4'h0;
	logic startup_done_i = 1'b0;
	logic [7:0] rw_bound_i = 8'h40;
	logic req_valid, req_ready_o, resp_valid_o, resp_grant_o, resp_decrypt_o, resp_clear_o, nv_lock_we_o;
	logic [3:0] req_cmd;
	logic [8:0] req_addr;
	logic [7:0] cfg_byte, lock_byte_o;
	logic [22:0] ctr_value;
	logic [2:0] resp_err_o;
	int bad_count = 0;
	int checked = 0;

	always #10 clock_i = ~clock_i;

	ealac_top #(.CTR_NUM(4)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.lock_load_valid_i(lock_load_valid_i), .lock_load_i(lock_load_i), .req_valid_i(req_valid),
		.req_ready_o(req_ready_o), .req_cmd_i(req_cmd), .req_addr_i(req_addr), .cfg_byte_i(cfg_byte),
		.ctr_value_i(ctr_value), .auth_valid_i(auth_valid_i), .auth_secret_i(auth_secret_i),
		.startup_done_i(startup_done_i), .rw_bound_i(rw_bound_i), .resp_valid_o(resp_valid_o),
		.resp_grant_o(resp_grant_o), .resp_err_o(resp_err_o), .resp_decrypt_o(resp_decrypt_o),
		.resp_clear_o(resp_clear_o), .lock_byte_o(lock_byte_o), .nv_lock_we_o(nv_lock_we_o));

	ealac_host host_u (.clock_i(clock_i), .req_ready_i(req_ready_o), .resp_valid_i(resp_valid_o),
		.resp_grant_i(resp_grant_o), .resp_err_i(resp_err_o), .resp_decrypt_i(resp_decrypt_o),
		.resp_clear_i(resp_clear_o), .nv_lock_we_i(nv_lock_we_o), .req_valid_o(req_valid),
		.req_cmd_o(req_cmd), .req_addr_o(req_addr), .cfg_byte_o(cfg_byte), .ctr_value_o(ctr_value));

	// --------------------------------
	// helpers
	// --------------------------------
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic t(input logic [3:0] cmd, input logic [8:0] addr, input logic [5:0] exp,
		input logic [7:0] cfg = 8'h00, input logic [22:0] ctr = 23'h000000);
		logic [6:0] ans;
		logic seen;
		host_u.issue(cmd, addr, cfg, ctr, ans, seen);
		cmp({7'h00, seen}, 8'h01);
		// store write strobe only for a granted lock
		cmp({1'b0, ans}, {1'b0, exp, exp[5] && cmd == LK});
	endtask

	task automatic boot(input logic [7:0] lb);
		@(posedge clock_i);
		#1;
		reset_n_i = 1'b0;
		repeat (4) @(posedge clock_i);
		#1;
		cmp(lock_byte_o, 8'hff);
		reset_n_i = 1'b1;
		lock_load_valid_i = 1'b1;
		lock_load_i = lb;
		@(posedge clock_i);
		#1;
		lock_load_valid_i = 1'b0;
		lock_load_i = ~lb;
		@(negedge clock_i);
		cmp(lock_byte_o, lb);
		cmp({7'h00, req_ready_o}, 8'h01);
	endtask

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		// about 340 cycles per request, far above need
		#400us;
		bad_count++;
		wrap_up();
	end

	initial begin
		boot(8'h54);
		t(PR, 9'h100, G);
		t(PW, 9'h100, G);
		t(CW, 9'h100, R2);
		t(HR, 9'h100, R2);
		t(PW, 9'h010, R2);
		t(PW, 9'h020, R2);
		t(PW, 9'h02e, R2);
		t(PR, 9'h000, R2);
		t(PR, 9'h02f, R2);
		t(PR, 9'h030, G);
		t(PW, 9'h070, G);
		t(PR, 9'h0af, G);
		t(PW, 9'h0d0, G);
		t(PR, 9'h0df, G);
		t(LK, 9'h000, G);
		cmp(lock_byte_o, 8'hff);
		t(LK, 9'h000, R2);
		boot(8'h56);
		t(PR, 9'h100, R2);
		t(HR, 9'h100, G);
		t(CW, 9'h100, GD);
		t(PW, 9'h100, G);
		t(HR, 9'h020, G);
		t(HR, 9'h01f, R2);
		t(CW, 9'h010, R2);
		t(CW, 9'h02e, R2);
		t(SF, 9'h000, G);
		t(PR, 9'h030, R2);
		t(LK, 9'h000, G);
		cmp(lock_byte_o, 8'hff);
		// undefined lock code: every memory access refused
		boot(8'h01);
		t(PR, 9'h100, R2);
		t(PW, 9'h100, R2);
		t(4'h9, 9'h100, R2);
		@(posedge clock_i);
		#1;
		lock_load_valid_i = 1'b1;
		lock_load_i = 8'h00;
		@(posedge clock_i);
		#1;
		lock_load_valid_i = 1'b0;
		cmp(lock_byte_o, 8'h01);
		boot(8'hff);
		t(PR, 9'h110, R4);
		@(posedge clock_i);
		#1;
		startup_done_i = 1'b1;
		t(PR, 9'h110, G);
		t(PR, 9'h13f, G);
		t(PW, 9'h110, R2);
		t(PW, 9'h13f, R2);
		t(PW, 9'h140, G);
		t(PR, 9'h140, G);
		t(CW, 9'h140, R2);
		t(HR, 9'h140, R2);
		t(PR, 9'h030, R2);
		t(PW, 9'h06f, R2);
		t(PW, 9'h070, R2);
		t(PR, 9'h0df, R2);
		t(PW, 9'h0d0, R2);
		t(PW, 9'h01f, R2);
		t(PW, 9'h020, R2);
		t(PR, 9'h02f, R2);
		t(CF, 9'h003, G);
		t(CB, 9'h000, G, 8'h00, 23'h61a7ff);
		// deliberate bump at the ceiling to see it refused
		t(CB, 9'h001, R2, 8'h00, 23'h61a800);
		t(CB, 9'h004, R2);
		t(PF, 9'h000, GC, 8'h01);
		t(PF, 9'h000, G, 8'h50);
		t(PF, 9'h000, R4, 8'h52);
		@(posedge clock_i);
		#1;
		auth_valid_i = 1'b1;
		auth_secret_i = 4'h5;
		t(PF, 9'h000, G, 8'h52);
		t(PF, 9'h000, GC, 8'h53);
		t(PF, 9'h000, R4, 8'h62);
		t(SF, 9'h000, G);
		t(LK, 9'h000, R2);
		cmp(lock_byte_o, 8'hff);
		wrap_up();
	end
endmodule // test_eeprom_lock_access_control
